// ### inc/spc_pkg.sv
// Package for the access protection checker: register map, field layouts and bus carriers.
package spc_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] SPC_ADDR_STATUS   = 8'h00;
  localparam logic [7:0] SPC_ADDR_MASK     = 8'h04;
  localparam logic [7:0] SPC_ADDR_MSTSEC   = 8'h08;
  localparam logic [7:0] SPC_ADDR_REGSEC   = 8'h0C;
  localparam logic [7:0] SPC_ADDR_REGPERM  = 8'h10;
  localparam logic [7:0] SPC_ADDR_REGNSC   = 8'h14;
  localparam logic [7:0] SPC_ADDR_PINSEC   = 8'h18;
  localparam logic [7:0] SPC_ADDR_CHSEC    = 8'h1C;
  localparam logic [7:0] SPC_ADDR_ERRADDR  = 8'h20;
  localparam logic [7:0] SPC_ADDR_ERRINFO  = 8'h24;

  // Status and mask bit positions
  localparam int SPC_ST_ACCERR  = 0;
  localparam int SPC_ST_PINERR  = 1;
  localparam int SPC_ST_CHERR   = 2;
  localparam int SPC_ST_BITS    = 3;

  // Permission field positions within one region nibble
  localparam int SPC_PERM_READ  = 0;
  localparam int SPC_PERM_WRITE = 1;
  localparam int SPC_PERM_EXEC  = 2;
  localparam int SPC_PERM_W     = 4;

  // Reset values
  localparam logic [31:0] SPC_RST_ZERO    = 32'h0000_0000;
  localparam logic [31:0] SPC_RST_ONES    = 32'hFFFF_FFFF;
  localparam logic [31:0] SPC_RST_PERM    = 32'h7777_7777;
  localparam logic [2:0]  SPC_RST_STATUS  = 3'h0;

  // Address decode of a transfer: region index bits
  localparam int SPC_REGION_LSB = 28;
  localparam int SPC_REGIONS    = 8;

  // Kinds of transfer violation
  typedef enum logic [1:0] {
    SPC_VIO_NONE,
    SPC_VIO_SEC,
    SPC_VIO_PERM
  } spc_vio_t;

  // One bus transfer from a master
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        exec;
    logic        cpu;
    logic        cpu_secure;
    logic [1:0]  master_id;
    logic [31:0] addr;
    logic [31:0] wdata;
  } spc_req_t;

  // Answer toward the master
  typedef struct packed {
    logic        valid;
    logic        bus_err;
    logic        sec_fault;
    logic [31:0] rdata;
  } spc_rsp_t;

  // Answer of the attribution logic to a target-test query
  typedef struct packed {
    logic       secure;
    logic       callable;
    logic [2:0] region;
  } spc_attr_t;

endpackage

// ### logic/spc_region_chk.sv
// Combinational check of one transfer against the region attribute tables.
`timescale 1ns/10ps
module spc_region_chk
  import spc_pkg::*;
#(
  parameter int REGIONS = SPC_REGIONS
) (
  // Transfer
  input  wire logic [31:0]           addr_i,
  input  wire logic                  write_i,
  input  wire logic                  exec_i,
  input  wire logic                  access_secure_i,
  // Region tables
  input  wire logic [REGIONS-1:0]    reg_sec_i,
  input  wire logic [REGIONS-1:0]    reg_callable_i,
  input  wire logic [REGIONS*4-1:0]  reg_perm_i,
  // Result
  output logic                       sec_vio_o,
  output logic                       perm_vio_o,
  output spc_attr_t                  attr_o
);

  localparam int IW = $clog2(REGIONS);

  wire logic [IW-1:0] idx  = addr_i[SPC_REGION_LSB +: IW];
  wire logic [3:0]    perm = reg_perm_i[idx*SPC_PERM_W +: SPC_PERM_W];
  wire logic          rsec = reg_sec_i[idx];
  // Callable entry regions only exist inside secure regions
  wire logic          rcall = reg_callable_i[idx] & rsec;

  // A non-secure access to a secure region is a security violation
  assign sec_vio_o  = rsec & ~access_secure_i;
  assign perm_vio_o = exec_i  ? ~perm[SPC_PERM_EXEC] :
                      write_i ? ~perm[SPC_PERM_WRITE] : ~perm[SPC_PERM_READ];
  assign attr_o     = '{secure: rsec, callable: rcall, region: 3'(idx)};

endmodule

// ### logic/spc_checker.sv
// Access protection checker: transfer gating, pin and channel guards, register port, interrupt.
`timescale 1ns/10ps
module spc_checker
  import spc_pkg::*;
#(
  parameter int REGIONS  = SPC_REGIONS,
  parameter int PINS     = 32,
  parameter int CHANNELS = 16,
  parameter int MASTERS  = 4
) (
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_n_i,
  // Register port
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic [31:0]                reg_rdata_o,
  // Transfer from masters
  input  spc_req_t                   req_i,
  output spc_rsp_t                   rsp_o,
  // Transfer toward the slave
  output spc_req_t                   slv_req_o,
  input  wire logic [31:0]           slv_rdata_i,
  // Pin and channel guard requests
  input  wire logic [$clog2(PINS)-1:0]     pin_sel_i,
  input  wire logic                        pin_req_i,
  input  wire logic                        pin_req_secure_i,
  output logic                             pin_grant_o,
  input  wire logic [$clog2(CHANNELS)-1:0] ch_sel_i,
  input  wire logic                        ch_req_i,
  input  wire logic                        ch_req_secure_i,
  output logic                             ch_grant_o,
  // Attribution query
  input  wire logic [31:0]           query_addr_i,
  output spc_attr_t                  query_attr_o,
  // Exceptions and interrupt
  output logic                       sec_fault_o,
  output logic                       bus_fault_o,
  output logic                       irq_o
);

  // Configuration registers
  logic [MASTERS-1:0]   mst_sec_r;
  logic [REGIONS-1:0]   reg_sec_r;
  logic [REGIONS*4-1:0] reg_perm_r;
  logic [REGIONS-1:0]   reg_call_r;
  logic [PINS-1:0]      pin_sec_r;
  logic [CHANNELS-1:0]  ch_sec_r;
  logic [SPC_ST_BITS-1:0] status_r;
  logic [SPC_ST_BITS-1:0] status_nxt;
  logic [SPC_ST_BITS-1:0] mask_r;
  logic [31:0]          err_addr_r;
  logic [31:0]          err_info_r;
  logic [31:0]          reg_rdata_r;
  spc_rsp_t             rsp_r;
  logic                 sec_fault_r;
  logic                 bus_fault_r;

  // Transfer security attribute
  wire logic access_secure = req_i.cpu ? req_i.cpu_secure
                                       : mst_sec_r[req_i.master_id];

  logic      sec_vio;
  logic      perm_vio;
  spc_attr_t req_attr;

  spc_region_chk #(
    .REGIONS (REGIONS)
  ) u_req_chk (
    .addr_i          (req_i.addr),
    .write_i         (req_i.write),
    .exec_i          (req_i.exec),
    .access_secure_i (access_secure),
    .reg_sec_i       (reg_sec_r),
    .reg_callable_i  (reg_call_r),
    .reg_perm_i      (reg_perm_r),
    .sec_vio_o       (sec_vio),
    .perm_vio_o      (perm_vio),
    .attr_o          (req_attr)
  );

  // Attribution query uses the same tables, security context does not matter
  spc_region_chk #(
    .REGIONS (REGIONS)
  ) u_query_chk (
    .addr_i          (query_addr_i),
    .write_i         (1'b0),
    .exec_i          (1'b0),
    .access_secure_i (1'b1),
    .reg_sec_i       (reg_sec_r),
    .reg_callable_i  (reg_call_r),
    .reg_perm_i      (reg_perm_r),
    .sec_vio_o       (),
    .perm_vio_o      (),
    .attr_o          (query_attr_o)
  );

  // Violation classification
  wire logic     any_vio   = req_i.valid & (sec_vio | perm_vio);
  wire logic     cpu_sec   = req_i.valid & req_i.cpu & sec_vio;
  wire logic     cpu_perm  = req_i.valid & req_i.cpu & ~sec_vio & perm_vio;
  wire logic     acc_event = any_vio & ~cpu_sec;
  wire spc_vio_t vio_kind  = ~any_vio ? SPC_VIO_NONE :
                             sec_vio  ? SPC_VIO_SEC  : SPC_VIO_PERM;

  // Forward only permitted transfers to the slave
  always_comb begin
    slv_req_o       = req_i;
    slv_req_o.valid = req_i.valid & ~any_vio;
  end

  // Pin and channel guards
  wire logic pin_ok = ~pin_sec_r[pin_sel_i] | pin_req_secure_i;
  wire logic ch_ok  = ~ch_sec_r[ch_sel_i]   | ch_req_secure_i;
  assign pin_grant_o = pin_req_i & pin_ok;
  assign ch_grant_o  = ch_req_i & ch_ok;

  // Register decode
  wire logic wr_mstsec  = reg_wr_i & (reg_addr_i == SPC_ADDR_MSTSEC);
  wire logic wr_regsec  = reg_wr_i & (reg_addr_i == SPC_ADDR_REGSEC);
  wire logic wr_regperm = reg_wr_i & (reg_addr_i == SPC_ADDR_REGPERM);
  wire logic wr_regnsc  = reg_wr_i & (reg_addr_i == SPC_ADDR_REGNSC);
  wire logic wr_pinsec  = reg_wr_i & (reg_addr_i == SPC_ADDR_PINSEC);
  wire logic wr_chsec   = reg_wr_i & (reg_addr_i == SPC_ADDR_CHSEC);
  wire logic wr_mask    = reg_wr_i & (reg_addr_i == SPC_ADDR_MASK);
  wire logic rd_status  = reg_rd_i & (reg_addr_i == SPC_ADDR_STATUS);

  // Sticky status: set wins over the read clear
  wire logic [SPC_ST_BITS-1:0] st_set = {ch_req_i & ~ch_ok,
                                         pin_req_i & ~pin_ok,
                                         acc_event};
  assign status_nxt = (rd_status ? SPC_RST_STATUS : status_r) | st_set;

  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = SPC_RST_ZERO;
    unique case (reg_addr_i)
      SPC_ADDR_STATUS:  rd_mux = 32'(status_r);
      SPC_ADDR_MASK:    rd_mux = 32'(mask_r);
      SPC_ADDR_MSTSEC:  rd_mux = 32'(mst_sec_r);
      SPC_ADDR_REGSEC:  rd_mux = 32'(reg_sec_r);
      SPC_ADDR_REGPERM: rd_mux = 32'(reg_perm_r);
      SPC_ADDR_REGNSC:  rd_mux = 32'(reg_call_r);
      SPC_ADDR_PINSEC:  rd_mux = 32'(pin_sec_r);
      SPC_ADDR_CHSEC:   rd_mux = 32'(ch_sec_r);
      SPC_ADDR_ERRADDR: rd_mux = err_addr_r;
      SPC_ADDR_ERRINFO: rd_mux = err_info_r;
      default:          rd_mux = SPC_RST_ZERO;
    endcase
  end

  // Configuration storage
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mst_sec_r  <= MASTERS'(SPC_RST_ZERO);
      reg_sec_r  <= REGIONS'(SPC_RST_ONES);
      reg_perm_r <= (REGIONS*4)'(SPC_RST_PERM);
      reg_call_r <= REGIONS'(SPC_RST_ZERO);
      pin_sec_r  <= PINS'(SPC_RST_ONES);
      ch_sec_r   <= CHANNELS'(SPC_RST_ONES);
      mask_r     <= SPC_ST_BITS'(SPC_RST_ZERO);
    end else begin
      if (wr_mstsec)  mst_sec_r  <= reg_wdata_i[MASTERS-1:0];
      if (wr_regsec)  reg_sec_r  <= reg_wdata_i[REGIONS-1:0];
      if (wr_regperm) reg_perm_r <= reg_wdata_i[REGIONS*4-1:0];
      if (wr_regnsc)  reg_call_r <= reg_wdata_i[REGIONS-1:0];
      if (wr_pinsec)  pin_sec_r  <= reg_wdata_i[PINS-1:0];
      if (wr_chsec)   ch_sec_r   <= reg_wdata_i[CHANNELS-1:0];
      if (wr_mask)    mask_r     <= reg_wdata_i[SPC_ST_BITS-1:0];
    end
  end

  // Status, error capture and register read data
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      status_r    <= SPC_RST_STATUS;
      err_addr_r  <= SPC_RST_ZERO;
      err_info_r  <= SPC_RST_ZERO;
      reg_rdata_r <= SPC_RST_ZERO;
    end else begin
      status_r    <= status_nxt;
      reg_rdata_r <= reg_rd_i ? rd_mux : SPC_RST_ZERO;
      if (any_vio) begin
        err_addr_r <= req_i.addr;
        err_info_r <= {24'h00_0000, req_i.master_id, req_i.cpu, req_i.exec,
                       req_i.write, access_secure, vio_kind};
      end
    end
  end

  // Answer to the master, one cycle after the request
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rsp_r       <= '0;
      sec_fault_r <= 1'b0;
      bus_fault_r <= 1'b0;
    end else begin
      rsp_r.valid     <= req_i.valid;
      rsp_r.bus_err   <= any_vio;
      rsp_r.sec_fault <= cpu_sec;
      rsp_r.rdata     <= (any_vio | req_i.write) ? SPC_RST_ZERO : slv_rdata_i;
      sec_fault_r     <= cpu_sec;
      bus_fault_r     <= cpu_perm;
    end
  end

  assign rsp_o       = rsp_r;
  assign sec_fault_o = sec_fault_r;
  assign bus_fault_o = bus_fault_r;
  assign reg_rdata_o = reg_rdata_r;
  assign irq_o       = |(status_r & mask_r);

endmodule

// ### verification/spc_checker_chk.sv
// Concurrent checks on the access protection checker ports.
`timescale 1ns/10ps
module spc_checker_chk
  import spc_pkg::*;
(
  // Clock, reset and register port
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [31:0] reg_rdata_o,
  // Transfers
  input  spc_req_t         req_i,
  input  spc_rsp_t         rsp_o,
  input  spc_req_t         slv_req_o,
  // Guards
  input  wire logic        pin_req_i,
  input  wire logic        pin_req_secure_i,
  input  wire logic        pin_grant_o,
  input  wire logic        ch_req_i,
  input  wire logic        ch_req_secure_i,
  input  wire logic        ch_grant_o,
  // Exceptions and interrupt
  input  wire logic        sec_fault_o,
  input  wire logic        bus_fault_o,
  input  wire logic        irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_cpu_req;
    req_i.valid && req_i.cpu;
  endsequence
  sequence s_blocked;
    req_i.valid && !slv_req_o.valid;
  endsequence
  sequence s_quiet_clear;
    reg_rd_i && reg_addr_i == SPC_ADDR_STATUS && !req_i.valid && !pin_req_i && !ch_req_i;
  endsequence
  a_rsp_follows_req: assert property (req_i.valid |=> rsp_o.valid)
    else $error("transfer got no response");
  a_blocked_reads_zero: assert property (s_blocked |=> rsp_o.bus_err && rsp_o.rdata == 0)
    else $error("blocked transfer answered wrongly");
  a_slave_pass_thru: assert property (slv_req_o.valid |-> req_i.valid &&
    slv_req_o.addr == req_i.addr && slv_req_o.write == req_i.write)
    else $error("slave sees a transfer not requested");
  a_sec_fault_first: assert property (s_cpu_req ##1 sec_fault_o |-> !bus_fault_o)
    else $error("bus fault beside security fault");
  a_cpu_one_fault: assert property (s_cpu_req ##1 rsp_o.bus_err |->
    sec_fault_o != bus_fault_o)
    else $error("processor violation without exactly one exception");
  a_rsp_sec_fault: assert property (rsp_o.sec_fault == sec_fault_o)
    else $error("response security fault differs from exception");
  a_fault_from_cpu: assert property (sec_fault_o || bus_fault_o |-> $past(req_i.valid && req_i.cpu))
    else $error("exception without processor transfer");
  a_other_no_fault: assert property (req_i.valid && !req_i.cpu |=> !sec_fault_o && !bus_fault_o)
    else $error("exception for other master");
  a_pin_guard: assert property (pin_req_i && pin_req_secure_i |-> pin_grant_o)
    else $error("secure requester refused a pin");
  a_pin_grant_req: assert property (pin_grant_o |-> pin_req_i)
    else $error("pin grant without request");
  a_ch_guard: assert property (ch_req_i && ch_req_secure_i |-> ch_grant_o)
    else $error("secure requester refused a channel");
  a_ch_grant_req: assert property (ch_grant_o |-> ch_req_i)
    else $error("channel grant without request");
  a_status_read_clears: assert property (s_quiet_clear |=> !irq_o)
    else $error("interrupt stays after status read");
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule
bind spc_checker spc_checker_chk u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .req_i(req_i),
  .rsp_o(rsp_o), .slv_req_o(slv_req_o), .pin_req_i(pin_req_i), .pin_grant_o(pin_grant_o),
  .pin_req_secure_i(pin_req_secure_i), .ch_req_i(ch_req_i), .ch_grant_o(ch_grant_o),
  .ch_req_secure_i(ch_req_secure_i), .sec_fault_o(sec_fault_o), .bus_fault_o(bus_fault_o),
  .irq_o(irq_o));

// ### verification/spc_slave_model.sv
// Combinational slave behind the checker, counting the writes it receives.
`timescale 1ns/10ps
module spc_slave_model
  import spc_pkg::*;
(
  input  wire logic   core_clk_i,
  input  spc_req_t    req_i,
  output logic [31:0] rdata_o,
  output int          wr_cnt_o
);
  logic tog_r = 1'b0;
  initial wr_cnt_o = 0;
  always @(posedge core_clk_i) tog_r <= ~tog_r;
  // Unselected bus shows a toggling pattern, never stale data
  assign rdata_o = req_i.valid ? ~req_i.addr : {32{tog_r}};
  always @(posedge core_clk_i) if (req_i.valid && req_i.write) wr_cnt_o <= wr_cnt_o + 1;
endmodule

// ### verification/spc_checker_tb.sv
// Self-checking bench for the access protection checker.
`timescale 1ns/10ps
module spc_checker_tb;
  import spc_pkg::*;
  logic        core_clk_i, rst_n_i, reg_wr_i, reg_rd_i, sec_fault_o, bus_fault_o, irq_o;
  logic        pin_req_i, pin_req_secure_i, pin_grant_o, ch_req_i, ch_req_secure_i, ch_grant_o;
  logic [7:0]  reg_addr_i;
  logic [4:0]  pin_sel_i;
  logic [3:0]  ch_sel_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, slv_rdata_i, query_addr_i, rn, a;
  logic [31:0] mst, rsec, perm, cal, psec, csec;
  spc_req_t    req_i, slv_req_o;
  spc_rsp_t    rsp_o;
  spc_attr_t   query_attr_o;
  int          error_cnt, comparisons, wr_cnt;
  logic [7:0]  rv_a [9] = '{SPC_ADDR_STATUS, SPC_ADDR_MASK, SPC_ADDR_MSTSEC, SPC_ADDR_REGSEC,
    SPC_ADDR_REGPERM, SPC_ADDR_REGNSC, SPC_ADDR_PINSEC, SPC_ADDR_CHSEC, 8'h30};
  logic [31:0] rv_d [9] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_00FF,
    32'h7777_7777, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_FFFF, 32'h0000_0000};
  spc_checker uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .req_i(req_i),
    .reg_rdata_o(reg_rdata_o), .rsp_o(rsp_o), .slv_req_o(slv_req_o), .slv_rdata_i(slv_rdata_i),
    .pin_sel_i(pin_sel_i), .pin_req_i(pin_req_i), .pin_req_secure_i(pin_req_secure_i),
    .pin_grant_o(pin_grant_o), .ch_sel_i(ch_sel_i), .ch_req_i(ch_req_i), .irq_o(irq_o),
    .ch_req_secure_i(ch_req_secure_i), .ch_grant_o(ch_grant_o), .query_addr_i(query_addr_i),
    .query_attr_o(query_attr_o), .sec_fault_o(sec_fault_o), .bus_fault_o(bus_fault_o));
  spc_slave_model u_slv (.core_clk_i(core_clk_i), .req_i(slv_req_o), .rdata_o(slv_rdata_i),
    .wr_cnt_o(wr_cnt));
  task automatic stop_test();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask
  task automatic xfer(input logic cpu, sec, w, ex, input logic [1:0] id, input logic [31:0] ad);
    logic [2:0] r;
    logic sv, pv, ev;
    int n;
    r = ad[30:28];
    sv = rsec[r] && !(cpu ? sec : mst[id]);
    pv = !perm[r*4 + (ex ? 2 : w ? 1 : 0)];
    ev = (sv || pv) && !(cpu && sv);
    n = wr_cnt;
    @(posedge core_clk_i);
    req_i <= '{valid: 1'b1, write: w, exec: ex, cpu: cpu, cpu_secure: sec, master_id: id,
      addr: ad, wdata: $urandom};
    #1 chk(slv_req_o.valid, !(sv || pv));
    @(posedge core_clk_i);
    req_i.valid <= 1'b0;
    #1 chk(rsp_o.bus_err, sv || pv);
    chk({rsp_o.valid, rsp_o.sec_fault}, {1'b1, cpu && sv});
    chk(rsp_o.rdata, (w || sv || pv) ? 32'h0000_0000 : ~ad);
    chk(32'(wr_cnt - n), w && !(sv || pv));
    chk(sec_fault_o, cpu && sv);
    chk(bus_fault_o, cpu && pv && !sv);
    chk(irq_o, ev && cal[31]);
    rd(SPC_ADDR_STATUS, {31'h0, ev});
    if (sv || pv) begin
      rd(SPC_ADDR_ERRADDR, ad);
      rd(SPC_ADDR_ERRINFO, {24'h00_0000, id, cpu, ex, w, cpu ? sec : mst[id],
        sv ? SPC_VIO_SEC : SPC_VIO_PERM});
    end
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
  initial begin
    {rst_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, query_addr_i} = '0;
    {pin_req_i, pin_req_secure_i, pin_sel_i, ch_req_i, ch_req_secure_i, ch_sel_i} = '0;
    req_i = '0;
    cal = '0;
    rn = $urandom(32'heee4);
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    foreach (rv_a[i]) rd(rv_a[i], rv_d[i]);
    wr(SPC_ADDR_STATUS, 32'hFFFF_FFFF);
    rd(SPC_ADDR_STATUS, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      mst = $urandom & 32'h0000_000F;
      rsec = ($urandom & 32'h0000_00FF) | 32'h0000_0001;
      perm = $urandom & 32'h7777_7770;
      cal[31] = k[0];
      wr(SPC_ADDR_MSTSEC, mst);
      wr(SPC_ADDR_REGSEC, rsec);
      wr(SPC_ADDR_REGPERM, perm);
      wr(SPC_ADDR_MASK, k ? 32'h0000_0007 : 32'h0000_0000);
      xfer(1'b1, 1'b0, 1'b0, 1'b0, 2'd0, 32'h8000_0004);
      repeat (25) begin
        rn = $urandom;
        xfer(rn[0], rn[1], rn[2], !rn[2] && rn[3], rn[5:4], $urandom);
      end
    end
    psec = $urandom;
    csec = $urandom & 32'h0000_FFFF;
    wr(SPC_ADDR_PINSEC, psec);
    wr(SPC_ADDR_CHSEC, csec);
    repeat (20) begin
      rn = $urandom;
      @(posedge core_clk_i);
      {pin_req_i, ch_req_i, pin_req_secure_i, ch_req_secure_i} <= {2'b11, rn[1:0]};
      {pin_sel_i, ch_sel_i} <= rn[12:4];
      #1 chk(pin_grant_o, !psec[rn[12:8]] || rn[1]);
      chk(ch_grant_o, !csec[rn[7:4]] || rn[0]);
      @(posedge core_clk_i);
      {pin_req_i, ch_req_i} <= 2'b00;
      #1 chk(irq_o, (psec[rn[12:8]] && !rn[1]) || (csec[rn[7:4]] && !rn[0]));
      rd(SPC_ADDR_STATUS, {29'h0, csec[rn[7:4]] && !rn[0], psec[rn[12:8]] && !rn[1], 1'b0});
    end
    cal = $urandom & 32'h0000_00FF;
    wr(SPC_ADDR_REGNSC, cal);
    repeat (10) begin
      a = $urandom;
      @(posedge core_clk_i);
      query_addr_i <= a;
      #1 chk(query_attr_o, {rsec[a[30:28]], rsec[a[30:28]] && cal[a[30:28]], a[30:28]});
    end
    stop_test();
  end
endmodule
